// *** include/gp_regs.svh ***
`ifndef GP_REGS_SVH
`define GP_REGS_SVH

// ==========================================
// register indices, byte address is index*4
`define GP_IDX_DIR 10'h012
`define GP_IDX_DATA 10'h013
`define GP_IDX_FUNC 10'h014
`define GP_IDX_BITOP 10'h015

// ==========================================
// reset values
`define GP_DIR_RST 8'hFF
`define GP_DATA_RST 8'h00
`define GP_FUNC_RST 10'h00F

// ==========================================
// bit operation fields and codes
`define GP_BOP_IDX_LSB 0
`define GP_BOP_OP_LSB 4
`define GP_OP_CLR 2'h0
`define GP_OP_SET 2'h1
`define GP_OP_TOG 2'h2

// ==========================================
// axi responses
`define GP_RESP_OKAY 2'h0
`define GP_RESP_SLVERR 2'h2

`endif

// *** include/gp_pkg.sv ***
package gp_pkg;

  // ==========================================
  // function select register layout
  typedef struct packed {
    logic vref_pos;
    logic vref_neg;
    logic serial_sync;
    logic serial_en;
    logic pwm_en;
    logic cap_en;
    logic [3:0] analog_en;
  } gp_func_t;

  // ==========================================
  // bit operation command
  typedef struct packed {
    logic [1:0] op;
    logic [2:0] idx;
  } gp_bitop_t;

  // ==========================================
  // per-pin alternate function request
  typedef struct packed {
    logic analog;
    logic en;
    logic o;
    logic oe;
  } gp_alt_t;

  typedef enum logic [1:0] {
    GP_W_COLLECT,
    GP_W_RESP
  } gp_wstate_t;

endpackage : gp_pkg

// *** verilog/gp_pin_cell.sv ***
`timescale 1ns/100ps

module gp_pin_cell
  import gp_pkg::*;
(
  input wire gp_alt_t alt, // alternate function request
  input wire logic latch, // output latch bit
  input wire logic dir, // 1 = input
  input wire logic level, // sampled pin level
  output logic pin_o, // pin drive value
  output logic pin_oe, // pin driver enable
  output logic din // digital read value
);

  // ==========================================
  // driver and input path
  always_comb begin
    if (alt.analog) begin
      pin_oe = 1'b0;
      pin_o = 1'b0;
    end else if (alt.en) begin
      pin_oe = alt.oe;
      pin_o = alt.o;
    end else begin
      pin_oe = ~dir;
      pin_o = latch;
    end
  end

  // analog pins read as zero digitally
  assign din = alt.analog ? 1'b0 : level;

endmodule : gp_pin_cell

// *** verilog/gp_port.sv ***
`timescale 1ns/100ps
`include "gp_regs.svh"

module gp_port
  import gp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [7:0] pin_i, // pin levels
  output logic [7:0] pin_o, // pin drive values
  output logic [7:0] pin_oe, // pin driver enables
  output logic [3:0] analog_channel_enable, // per converter channel
  output logic vref_neg_enable, // pin two is negative reference
  output logic vref_pos_enable, // pin three is positive reference
  output logic third_capture_input, // pin four level to capture
  input wire logic third_pulse_width_output, // pwm drive for pin five
  input wire logic second_serial_transmit, // async transmit
  output logic second_serial_receive, // async receive
  input wire logic second_serial_sync_data_out, // sync data drive
  input wire logic second_serial_sync_data_oe, // sync data enable
  output logic second_serial_sync_data_in, // sync data level
  input wire logic second_serial_sync_clock_out, // sync clock drive
  input wire logic second_serial_sync_clock_oe, // sync clock enable
  output logic second_serial_sync_clock_in // sync clock level
);

  // ==========================================
  // state
  logic [7:0] pin_data_latch;
  logic [7:0] pin_direction_control;
  gp_func_t func;
  logic [7:0] pin_sample;
  logic [7:0] din;
  gp_alt_t alt [8];
  gp_wstate_t wstate;
  logic aw_hold;
  logic w_hold;
  logic [9:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_go;
  logic wr_hit;
  logic ar_go;
  logic [9:0] rd_idx;
  gp_bitop_t bop;
  logic bop_go;
  logic [7:0] next_bop_byte;

  // ==========================================
  // pin sampling at start of cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_sample <= 8'h00;
    end else begin
      pin_sample <= pin_i;
    end
  end

  // ==========================================
  // alternate function selection
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      alt[i] = '0;
    end
    for (int i = 0; i < 4; i++) begin
      alt[i].analog = func.analog_en[i];
    end
    alt[4].en = func.cap_en;
    alt[5].en = func.pwm_en;
    alt[5].o = third_pulse_width_output;
    alt[5].oe = 1'b1;
    alt[6].en = func.serial_en;
    alt[6].o = func.serial_sync & second_serial_sync_data_out;
    alt[6].oe = func.serial_sync & second_serial_sync_data_oe;
    alt[7].en = func.serial_en;
    alt[7].o = func.serial_sync ? second_serial_sync_clock_out
                                : second_serial_transmit;
    alt[7].oe = func.serial_sync ? second_serial_sync_clock_oe : 1'b1;
  end

  // ==========================================
  // one cell per pin
  for (genvar g = 0; g < 8; g++) begin : g_pin
    gp_pin_cell u_cell (
      .alt(alt[g]),
      .latch(pin_data_latch[g]),
      .dir(pin_direction_control[g]),
      .level(pin_sample[g]),
      .pin_o(pin_o[g]),
      .pin_oe(pin_oe[g]),
      .din(din[g])
    );
  end

  // ==========================================
  // peripheral side outputs
  assign analog_channel_enable = {func.analog_en[0], func.analog_en[1],
                                  func.analog_en[2], func.analog_en[3]};
  assign vref_neg_enable = func.vref_neg & func.analog_en[2];
  assign vref_pos_enable = func.vref_pos & func.analog_en[3];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      third_capture_input <= 1'b0;
      second_serial_receive <= 1'b1;
      second_serial_sync_data_in <= 1'b0;
      second_serial_sync_clock_in <= 1'b0;
    end else begin
      third_capture_input <= func.cap_en & pin_i[4];
      second_serial_receive <= ~(func.serial_en & ~func.serial_sync) |
                               pin_i[6];
      second_serial_sync_data_in <= func.serial_en & func.serial_sync &
                                    pin_i[6];
      second_serial_sync_clock_in <= func.serial_en & func.serial_sync &
                                     pin_i[7];
    end
  end

  // ==========================================
  // write channel
  assign s_axi_awready = (wstate == GP_W_COLLECT) && !aw_hold;
  assign s_axi_wready = (wstate == GP_W_COLLECT) && !w_hold;
  assign s_axi_bvalid = (wstate == GP_W_RESP);
  assign wr_go = (wstate == GP_W_COLLECT) && aw_hold && w_hold;
  assign wr_hit = (wr_idx == `GP_IDX_DIR) || (wr_idx == `GP_IDX_DATA) ||
                  (wr_idx == `GP_IDX_FUNC) || (wr_idx == `GP_IDX_BITOP);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_hold <= 1'b0;
      wr_idx <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold <= 1'b1;
      wr_idx <= s_axi_awaddr[11:2];
    end else if (wr_go) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_hold <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wstate <= GP_W_COLLECT;
      s_axi_bresp <= `GP_RESP_OKAY;
    end else begin
      case (wstate)
        GP_W_COLLECT: begin
          if (wr_go) begin
            wstate <= GP_W_RESP;
            s_axi_bresp <= wr_hit ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
          end
        end
        GP_W_RESP: begin
          if (s_axi_bready) begin
            wstate <= GP_W_COLLECT;
          end
        end
        default: begin
          wstate <= GP_W_COLLECT;
        end
      endcase
    end
  end

  // ==========================================
  // register updates
  assign bop = gp_bitop_t'({wr_data[`GP_BOP_OP_LSB +: 2],
                            wr_data[`GP_BOP_IDX_LSB +: 3]});
  assign bop_go = wr_go && (wr_idx == `GP_IDX_BITOP) && wr_strb[0];

  // read pins, change one bit, write the byte back
  always_comb begin
    next_bop_byte = din;
    case (bop.op)
      `GP_OP_CLR: next_bop_byte[bop.idx] = 1'b0;
      `GP_OP_SET: next_bop_byte[bop.idx] = 1'b1;
      `GP_OP_TOG: next_bop_byte[bop.idx] = ~din[bop.idx];
      default: next_bop_byte = din;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_data_latch <= `GP_DATA_RST;
    end else if (wr_go && (wr_idx == `GP_IDX_DATA) && wr_strb[0]) begin
      pin_data_latch <= wr_data[7:0];
    end else if (bop_go) begin
      pin_data_latch <= next_bop_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_direction_control <= `GP_DIR_RST;
    end else if (wr_go && (wr_idx == `GP_IDX_DIR) && wr_strb[0]) begin
      pin_direction_control <= wr_data[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      func <= gp_func_t'(`GP_FUNC_RST);
    end else if (wr_go && (wr_idx == `GP_IDX_FUNC)) begin
      if (wr_strb[0]) begin
        func[7:0] <= wr_data[7:0];
      end
      if (wr_strb[1]) begin
        func[9:8] <= wr_data[9:8];
      end
    end
  end

  // ==========================================
  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[11:2];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `GP_RESP_OKAY;
    end else if (ar_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `GP_RESP_OKAY;
      case (rd_idx)
        `GP_IDX_DIR: s_axi_rdata <= {24'h000000, pin_direction_control};
        `GP_IDX_DATA: s_axi_rdata <= {24'h000000, din};
        `GP_IDX_FUNC: s_axi_rdata <= {22'h000000, func};
        `GP_IDX_BITOP: s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `GP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_plain_pin_drive: assert property (
    (!func.pwm_en && !func.serial_en) |->
      ((pin_oe[7:5] == ~pin_direction_control[7:5]) &&
       (((pin_o[7:5] ^ pin_data_latch[7:5]) & pin_oe[7:5]) == 3'h0)))
    else $error("plain pin drive mismatch");

  a_read_pins_back: assert property (
    (ar_go && rd_idx == `GP_IDX_DATA) |=>
      (s_axi_rvalid && s_axi_rdata[7:0] == $past(din)))
    else $error("data read not pin levels");

  a_write_latch_only: assert property (
    (wr_go && wr_idx == `GP_IDX_DATA && wr_strb[0]) |=>
      (pin_data_latch == $past(wr_data[7:0]) &&
       $stable(pin_direction_control)))
    else $error("data write wrong effect");

  a_analog_undriven: assert property (
    (func.analog_en & pin_oe[3:0]) == 4'h0)
    else $error("analog pin driven");

  a_capture_follows: assert property (
    func.cap_en |=> (third_capture_input == $past(pin_i[4])))
    else $error("capture input not pin level");

  a_pwm_on_pin: assert property (
    func.pwm_en |-> (pin_oe[5] && pin_o[5] == third_pulse_width_output))
    else $error("pwm not on pin five");

  a_serial_async_pins: assert property (
    (func.serial_en && !func.serial_sync) |->
      (!pin_oe[6] && pin_oe[7] && pin_o[7] == second_serial_transmit))
    else $error("async serial pins wrong");

  a_serial_sync_clk: assert property (
    (func.serial_en && func.serial_sync) |->
      (pin_oe[7] == second_serial_sync_clock_oe))
    else $error("sync clock enable wrong");

  a_reset_analog: assert property (
    $fell(sys_rst) |->
      (func.analog_en == 4'hF && pin_direction_control == 8'hFF &&
       pin_oe == 8'h00))
    else $error("reset not analog inputs");

  a_bitop_rmw: assert property (
    bop_go |=> ((((pin_data_latch ^ $past(din)) &
                 ~(8'h01 << $past(bop.idx))) == 8'h00)))
    else $error("bit operation lost pin level");

  a_write_timing: assert property (
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=>
      wr_go ##1 s_axi_bvalid)
    else $error("write not done next cycle");

  c_data_write: cover property (wr_go && wr_idx == `GP_IDX_DATA);
  c_bitop: cover property (bop_go && bop.op == `GP_OP_TOG);
  c_data_read: cover property (ar_go && rd_idx == `GP_IDX_DATA);
  c_sync_serial: cover property (func.serial_en && func.serial_sync);

endmodule : gp_port

// *** tb/gp_pin_model.sv ***
`timescale 1ns/100ps

// ==========================================
// external pin load: resolves each pin's level
module gp_pin_model (
  input wire logic clk, // system clock
  input wire logic [7:0] pin_o, // port drive values
  input wire logic [7:0] pin_oe, // port driver enables
  input wire logic [7:0] ext_val, // external source levels
  input wire logic [7:0] ext_en, // external source enables
  output logic [7:0] pin_i // resolved pin levels
);
  logic [7:0] wander = 8'h55;

  // undriven pins change every cycle so stale levels never pass
  always @(posedge clk) begin
    wander <= ~wander;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : wander[i]);
    end
  end
endmodule : gp_pin_model

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`include "gp_regs.svh"

module tb_top;
  import gp_pkg::*;
  typedef struct packed {
    logic [7:0] dir, latch, ext, oe, o, rd;
  } gp_row_t;
  localparam logic [11:0] A_DIR = {`GP_IDX_DIR, 2'b00};
  localparam logic [11:0] A_DATA = {`GP_IDX_DATA, 2'b00};
  localparam logic [11:0] A_FUNC = {`GP_IDX_FUNC, 2'b00};
  localparam logic [11:0] A_BOP = {`GP_IDX_BITOP, 2'b00};
  logic clk = 1'b0, sys_rst = 1'b1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic pwm = 1'b0, stx = 1'b0, sdo = 1'b0, sdoe = 1'b0, sco = 1'b0, scoe = 1'b0;
  logic [7:0] ext_val = 8'hA5, pin_i, pin_o, pin_oe;
  logic awready, wready, bvalid, arready, rvalid, vn, vp, cap, srx, sdi, sci;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] ace;
  int errors = 0, compares = 0, cyc = 0;
  gp_row_t rows [3] = '{'{8'h00, 8'hA5, 8'h3C, 8'hFF, 8'hA5, 8'hA5},
                        '{8'hFF, 8'h3C, 8'h96, 8'h00, 8'h00, 8'h96},
                        '{8'h0F, 8'hF0, 8'h0A, 8'hF0, 8'hF0, 8'hFA}};
  logic [7:0] cmds [4] = '{8'h17, 8'h20, 8'h07, 8'h30};
  logic [7:0] exps [4] = '{8'h85, 8'h84, 8'h04, 8'h04};

  always #5 clk = ~clk;

  gp_port uut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .analog_channel_enable(ace),
    .vref_neg_enable(vn), .vref_pos_enable(vp), .third_capture_input(cap),
    .third_pulse_width_output(pwm), .second_serial_transmit(stx),
    .second_serial_receive(srx), .second_serial_sync_data_out(sdo),
    .second_serial_sync_data_oe(sdoe), .second_serial_sync_data_in(sdi),
    .second_serial_sync_clock_out(sco), .second_serial_sync_clock_oe(scoe),
    .second_serial_sync_clock_in(sci));

  gp_pin_model pins (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(8'hFF), .pin_i(pin_i));

  // ==========================================
  // reporting
  task wrap_up;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // ==========================================
  // bus master
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
    cmp(32'(r), 32'(er));
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
    rready <= 1'b0;
    cmp(d, ed);
    cmp(32'(r), 32'(er));
  endtask : rd

  task settle;
    repeat (3) @(posedge clk);
  endtask : settle

  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    cmp(32'({pin_oe, 3'h0, srx, ace}), 32'h01F);
    rd(A_DIR, 32'hFF, `GP_RESP_OKAY);
    rd(A_FUNC, 32'h00F, `GP_RESP_OKAY);
    rd(A_DATA, 32'hA0, `GP_RESP_OKAY);
    wr(12'h7FC, 32'h5A, `GP_RESP_SLVERR);
    rd(12'h7FC, 32'h0, `GP_RESP_SLVERR);
    rd(A_BOP, 32'h0, `GP_RESP_OKAY);
    wr(A_FUNC, 32'h0, `GP_RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      ext_val <= rows[i].ext;
      wr(A_DIR, 32'(rows[i].dir), `GP_RESP_OKAY);
      wr(A_DATA, 32'(rows[i].latch), `GP_RESP_OKAY);
      settle();
      cmp(32'({pin_oe, pin_o & pin_oe}), 32'({rows[i].oe, rows[i].o}));
      rd(A_DATA, 32'(rows[i].rd), `GP_RESP_OKAY);
    end
    ext_val <= 8'hA5;
    wr(A_DIR, 32'h0F, `GP_RESP_OKAY);
    wr(A_DATA, 32'h00, `GP_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(A_BOP, 32'(cmds[i]), `GP_RESP_OKAY);
      if (i == 0) wr(A_DIR, 32'h00, `GP_RESP_OKAY);
      settle();
      cmp(32'(pin_o), 32'(exps[i]));
    end
    wr(A_FUNC, 32'h001, `GP_RESP_OKAY);
    settle();
    cmp(32'({ace, 3'h0, pin_oe[0]}), 32'h80);
    rd(A_DATA, 32'h04, `GP_RESP_OKAY);
    wr(A_FUNC, 32'h30F, `GP_RESP_OKAY);
    cmp(32'({2'h0, vp, vn, ace}), 32'h3F);
    ext_val <= 8'h1A;
    pwm <= 1'b1;
    stx <= 1'b1;
    wr(A_FUNC, 32'h070, `GP_RESP_OKAY);
    settle();
    cmp(32'({pin_oe[7:4], pin_o[7:4] & pin_oe[7:4], 2'h0, cap, srx}), 32'hAA2);
    pwm <= 1'b0;
    stx <= 1'b0;
    settle();
    cmp(32'(pin_o[7:4] & pin_oe[7:4]), 32'h0);
    ext_val <= 8'h9A;
    sdo <= 1'b1;
    sdoe <= 1'b1;
    wr(A_FUNC, 32'h0F0, `GP_RESP_OKAY);
    settle();
    cmp(32'({pin_oe[7:4], pin_o[7:4] & pin_oe[7:4], 2'h0, sci, sdi}), 32'h643);
    // sync clock driven high against a low external level
    ext_val <= 8'h1A;
    sco <= 1'b1;
    scoe <= 1'b1;
    sdoe <= 1'b0;
    settle();
    cmp(32'({pin_oe[7:6], pin_o[7:6] & pin_oe[7:6], sci, sdi}), 32'h2A);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    cmp(32'({pin_oe, ace}), 32'h00F);
    // a write with no strobes must leave the register alone
    wstrb <= 4'h0;
    wr(A_DIR, 32'h00, `GP_RESP_OKAY);
    wstrb <= 4'hF;
    rd(A_DIR, 32'hFF, `GP_RESP_OKAY);
    rd(A_FUNC, 32'h00F, `GP_RESP_OKAY);
    wrap_up();
  end
endmodule : tb_top
